// file: design/lowside_channel_fault_diag.v
/*
 * Top of the eight-channel fault and diagnosis logic. Synchronises the
 * analog comparator levels, the reset pin and the limp-home pin, qualifies
 * reset and limp-home by a minimum duration, and collects the flags.
 * Assumes the serial interface outside supplies the command word.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fault_diag_defines.vh"

module lowside_channel_fault_diag #(
    parameter integer CHANNELS = 8,                  // Number of channels
    parameter integer OVL_CYC  = `OVL_DELAY_CYC,     // Overload delay cycles
    parameter integer OL_CYC   = `OL_DELAY_CYC,      // Open-load delay cycles
    parameter integer HOLD_CYC = `RST_HOLD_CYC       // Reset/limp-home qualify
) (
    input  wire                  clk,                // System clock
    input  wire                  nrst,               // Synchronous reset, active low
    input  wire                  reset_pin_n,        // Device reset pin, active low
    input  wire                  limp_home_input,    // Limp-home pin, active high
    input  wire [2*CHANNELS-1:0] cmd_word,           // Channel commands, 2 bits each
    input  wire                  cmd_load,           // Strobe: take cmd_word
    input  wire [CHANNELS-1:0]   overload,           // Overload comparators
    input  wire [CHANNELS-1:0]   over_temp,          // Thermal sensors
    input  wire [CHANNELS-1:0]   open_load,          // Open-load comparators
    output wire [CHANNELS-1:0]   gate_on,            // Switch drives
    output wire [CHANNELS-1:0]   diag_current_en,    // Diagnosis current sources
    output reg  [2*CHANNELS-1:0] diag_word,          // Flag pairs, registered
    output wire [2*CHANNELS-1:0] cmd_state,          // Present command word
    output wire                  held                // Reset/limp-home active
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    reg [3*CHANNELS+1:0] sync1_reg;                  // First stage only
    reg [3*CHANNELS+1:0] sync2_reg;                  // Second stage, read by logic

    always @(posedge clk) begin
        if (!nrst) begin
            sync1_reg <= {(3*CHANNELS+2){1'b0}};
            sync2_reg <= {(3*CHANNELS+2){1'b0}};
        end else begin
            sync1_reg <= {!reset_pin_n, limp_home_input, open_load, over_temp, overload};
            sync2_reg <= sync1_reg;
        end
    end

    wire [CHANNELS-1:0] ovl_s = sync2_reg[CHANNELS-1:0];
    wire [CHANNELS-1:0] ot_s  = sync2_reg[2*CHANNELS-1:CHANNELS];
    wire [CHANNELS-1:0] ol_s  = sync2_reg[3*CHANNELS-1:2*CHANNELS];
    wire                req_s = sync2_reg[3*CHANNELS] | sync2_reg[3*CHANNELS+1];

    // ==========================================================
    // Reset / limp-home duration qualifier
    // ==========================================================
    reg [`CNT_W-1:0] hold_cnt_reg;                   // Cycles the request has stood
    reg              held_reg;                       // Qualified hold

    always @(posedge clk) begin
        if (!nrst) begin
            hold_cnt_reg <= 16'h0000;
            held_reg     <= 1'b0;
        end else if (!req_s) begin
            hold_cnt_reg <= 16'h0000;                // Short pulse ignored
            held_reg     <= 1'b0;
        end else if (hold_cnt_reg == HOLD_CYC[`CNT_W-1:0] - 16'h0001) begin
            held_reg     <= 1'b1;
        end else begin
            hold_cnt_reg <= hold_cnt_reg + 16'h0001;
        end
    end

    assign held = held_reg;

    // ==========================================================
    // Command register
    // ==========================================================
    reg [2*CHANNELS-1:0] cmd_reg;                    // Per-channel command codes

    always @(posedge clk) begin
        if (!nrst || held_reg) begin
            cmd_reg <= `CMD_RESET_VALUE;             // Idle on all channels
        end else if (cmd_load) begin
            cmd_reg <= cmd_word;
        end
    end

    assign cmd_state = cmd_reg;

    // ==========================================================
    // Channels
    // ==========================================================
    wire [CHANNELS-1:0] pf;                          // Protection flags
    wire [CHANNELS-1:0] olf;                         // Open-load flags

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : ch
            channel_fault #(
                .OVL_CYC (OVL_CYC),
                .OL_CYC  (OL_CYC)
            ) u_ch (
                .clk                   (clk),
                .nrst                  (nrst),
                .hold                  (held_reg),
                .cmd                   (cmd_reg[2*i+1:2*i]),
                .overload              (ovl_s[i]),
                .over_temp             (ot_s[i]),
                .open_load             (ol_s[i]),
                .gate_on               (gate_on[i]),
                .diag_current_en       (diag_current_en[i]),
                .protection_fault_flag (pf[i]),
                .open_load_flag        (olf[i])
            );
        end
    endgenerate

    // ==========================================================
    // Diagnosis word: pair n = {protection, open-load}
    // ==========================================================
    integer k;
    always @(posedge clk) begin
        if (!nrst) begin
            diag_word <= `DIAG_RESET_VALUE;
        end else begin
            for (k = 0; k < CHANNELS; k = k + 1) begin
                diag_word[2*k+1] <= pf[k];
                diag_word[2*k]   <= olf[k];
            end
        end
    end

endmodule
`default_nettype wire

// file: common/fault_diag_defines.vh
/*
 * Constants for the eight-channel low-side fault and diagnosis logic:
 * channel command codes, delay figures, cycle counts and reset values.
 * Assumes a 100 MHz system clock; included by the design files by bare name.
 */
`ifndef FAULT_DIAG_DEFINES_VH
`define FAULT_DIAG_DEFINES_VH

// ==========================================================
// Clock
// ==========================================================
`define CLK_MHZ              100

// ==========================================================
// Channel command codes
// ==========================================================
`define CMD_STANDBY          2'h0
`define CMD_ON               2'h1
`define CMD_OFF              2'h2
`define CMD_IDLE             2'h3
`define CMD_RESET_VALUE      16'hFFFF
`define DIAG_RESET_VALUE     16'hFFFF

// ==========================================================
// Timing: figures in us, counts in cycles
// ==========================================================
`define OVL_DELAY_US         10
`define OVL_DELAY_CYC        (`OVL_DELAY_US * `CLK_MHZ)
`define OL_DELAY_US          100
`define OL_DELAY_CYC         (`OL_DELAY_US * `CLK_MHZ)
`define RST_HOLD_US          50
`define RST_HOLD_CYC         (`RST_HOLD_US * `CLK_MHZ)
`define CNT_W                16

`endif

// file: design/channel_fault.v
/*
 * One channel's protection and off-state diagnosis: overload qualification,
 * over-temperature shutdown, open-load timing and the two latched flags.
 * Assumes its analog inputs are already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fault_diag_defines.vh"

module channel_fault #(
    parameter integer OVL_CYC = `OVL_DELAY_CYC,  // Overload qualification cycles
    parameter integer OL_CYC  = `OL_DELAY_CYC    // Open-load qualification cycles
) (
    input  wire       clk,             // System clock
    input  wire       nrst,            // Synchronous reset, active low
    input  wire       hold,            // Reset or limp-home active
    input  wire [1:0] cmd,             // Channel command code
    input  wire       overload,        // Overload comparator, synchronised
    input  wire       over_temp,       // Thermal sensor trip, synchronised
    input  wire       open_load,       // Off-state open-load comparator
    output reg        gate_on,         // Output switch drive
    output reg        diag_current_en, // Off-state diagnosis current source
    output reg        protection_fault_flag,
    output reg        open_load_flag
);

    // ==========================================================
    // Counters
    // ==========================================================
    reg [`CNT_W-1:0] ovl_cnt_reg;      // Overload qualification timer
    reg [`CNT_W-1:0] ol_cnt_reg;       // Open-load qualification timer

    wire standby   = (cmd == `CMD_STANDBY);
    wire want_on   = (cmd == `CMD_ON) && !hold;
    // Off-state diagnosis only when off and not standby
    wire diag_en   = !standby && !gate_on && !hold;
    wire ovl_trip  = gate_on && overload &&
                     (ovl_cnt_reg == OVL_CYC[`CNT_W-1:0] - 16'h0001);
    wire ol_trip   = diag_en && open_load &&
                     (ol_cnt_reg == OL_CYC[`CNT_W-1:0] - 16'h0001);

    // ==========================================================
    // Overload and open-load timers
    // ==========================================================
    always @(posedge clk) begin
        if (!nrst) begin
            ovl_cnt_reg <= 16'h0000;
            ol_cnt_reg  <= 16'h0000;
        end else begin
            // Overload timer restarts when current falls back
            if (gate_on && overload && !ovl_trip) begin
                ovl_cnt_reg <= ovl_cnt_reg + 16'h0001;
            end else begin
                ovl_cnt_reg <= 16'h0000;
            end
            // Open-load timer runs only in off-state diagnosis
            if (diag_en && open_load && !ol_trip) begin
                ol_cnt_reg <= ol_cnt_reg + 16'h0001;
            end else begin
                ol_cnt_reg <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Flags and switch drive
    // ==========================================================
    always @(posedge clk) begin
        if (!nrst) begin
            gate_on               <= 1'b0;
            diag_current_en       <= 1'b0;
            protection_fault_flag <= 1'b1;
            open_load_flag        <= 1'b1;
        end else begin
            // Protection flag: overload or thermal, cleared only by standby
            if (ovl_trip || over_temp) begin
                protection_fault_flag <= 1'b1;
            end else if (standby) begin
                protection_fault_flag <= 1'b0;
            end
            // Open-load flag, untouched while on
            if (ol_trip) begin
                open_load_flag <= 1'b1;
            end else if (standby) begin
                open_load_flag <= 1'b0;
            end
            // Switch on only with no protection flag pending
            if (ovl_trip || over_temp) begin
                gate_on <= 1'b0;
            end else begin
                gate_on <= want_on && !protection_fault_flag;
            end
            diag_current_en <= !standby && !want_on && !hold;
        end
    end

endmodule
`default_nettype wire

// file: tb/fault_diag_properties.sv
/* Checker on the fault logic top, channel 0 in detail.
   Assumes the small delay parameters that the bench sets. */
`timescale 1ns/1ps
`default_nettype none
module fault_diag_properties #(
    parameter integer CHANNELS = 8,
    parameter integer OVL_CYC  = 4,
    parameter integer OL_CYC   = 6,
    parameter integer HOLD_CYC = 4
) (
    input wire                  clk,
    input wire                  nrst,
    input wire                  reset_pin_n,
    input wire                  held,
    input wire                  cmd_load,
    input wire [2*CHANNELS-1:0] cmd_word,
    input wire [2*CHANNELS-1:0] cmd_state,
    input wire [2*CHANNELS-1:0] diag_word,
    input wire [CHANNELS-1:0]   overload,
    input wire [CHANNELS-1:0]   over_temp,
    input wire [CHANNELS-1:0]   open_load,
    input wire [CHANNELS-1:0]   gate_on,
    input wire [CHANNELS-1:0]   diag_current_en
);
    // ==================================================
    // Timing relations, one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_ovl; (gate_on[0] && overload[0])[*6]; endsequence
    sequence s_ol; (open_load[0] && cmd_state[1:0] == 2'h2)[*8]; endsequence
    property p_init; $rose(nrst) |-> !gate_on && cmd_state == 16'hFFFF
        && diag_word == 16'hFFFF; endproperty
    a_init: assert property (p_init) else $error("bad reset state");
    property p_prot; diag_word[1] |-> !gate_on[0]; endproperty
    a_prot: assert property (p_prot) else $error("on with flag");
    property p_ovl; s_ovl |=> !gate_on[0] ##[0:2] diag_word[1]; endproperty
    a_ovl: assert property (p_ovl) else $error("overload kept on");
    property p_ot; $rose(over_temp[0]) ##1 over_temp[0][*2] |-> ##[0:3] diag_word[1]; endproperty
    a_ot: assert property (p_ot) else $error("over-temp no flag");
    property p_latch; diag_word[1] && cmd_state[1:0] != 2'h0 |=> diag_word[1]; endproperty
    a_latch: assert property (p_latch) else $error("flag lost");
    property p_stb; (cmd_state[1:0] == 2'h0)[*4] |-> !diag_word[0] && !gate_on[0]
        && !diag_current_en[0]; endproperty
    a_stb: assert property (p_stb) else $error("standby wrong");
    property p_ol; s_ol |-> ##[1:4] diag_word[0]; endproperty
    a_ol: assert property (p_ol) else $error("open load missed");
    property p_olon; gate_on[0][*3] ##0 !diag_word[0] |=> !diag_word[0]; endproperty
    a_olon: assert property (p_olon) else $error("diag while on");
    property p_take; cmd_load && !held |=> cmd_state == $past(cmd_word); endproperty
    a_take: assert property (p_take) else $error("command not taken");
    property p_clear; cmd_load && !held && cmd_word[1:0] == 2'h0 && !over_temp[0]
        |-> ##[2:3] diag_word[1:0] == 2'h0; endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_hold; (!reset_pin_n)[*8] |-> ##[0:2] held; endproperty
    a_hold: assert property (p_hold) else $error("reset pin ignored");
    property p_held; held[*3] |-> cmd_state == 16'hFFFF && !gate_on; endproperty
    a_held: assert property (p_held) else $error("held not idle");
endmodule
bind lowside_channel_fault_diag fault_diag_properties #(.CHANNELS(CHANNELS)) u_props (.clk(clk),
    .nrst(nrst), .reset_pin_n(reset_pin_n), .held(held), .cmd_load(cmd_load),
    .cmd_word(cmd_word), .cmd_state(cmd_state), .diag_word(diag_word),
    .overload(overload), .over_temp(over_temp), .open_load(open_load),
    .gate_on(gate_on), .diag_current_en(diag_current_en));
`default_nettype wire

// file: tb/host_model.sv
/* Host model: issues channel commands, drives reset and limp-home pins.
   Assumes the bench clock; every change lands at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire         clk,
    output logic        reset_pin_n,
    output logic        limp_home_input,
    output logic [15:0] cmd_word,
    output logic        cmd_load
);
    // Pins inactive, no command pending
    initial begin
        {reset_pin_n, limp_home_input, cmd_load, cmd_word} = 19'h40000;
    end
    // One-cycle strobe; code 00 programs standby to clear flags
    task automatic send(input logic [15:0] w);
        @(negedge clk);
        cmd_word = w;
        cmd_load = 1'b1;
        @(negedge clk);
        cmd_load = 1'b0;
        cmd_word = ~w;
    endtask
    // Pin level; the caller keeps it past the qualify time
    task automatic pins(input logic lh, input logic on);
        @(negedge clk);
        if (lh) limp_home_input = on;
        else reset_pin_n = !on;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
/* Bench for the fault logic top: host model, random commands, corner cases.
   Assumes short delay parameters; bench functions give the expectations. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam integer OVL = 4;
    localparam integer OL = 6;
    localparam integer HLD = 4;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  overload = 8'h00;
    logic [7:0]  over_temp = 8'h00;
    logic [7:0]  open_load = 8'h00;
    logic [7:0]  gate_on, diag_current_en;
    logic [15:0] cmd_word, cmd_state, diag_word, w;
    logic        reset_pin_n, limp_home_input, cmd_load, held;
    logic [31:0] rng = 32'h24CCBA0D;
    integer      n_mismatch = 0, n_compared = 0, i, k;
    // ==================================================
    // Clock, host model and design
    always #5 clk = ~clk;
    host_model host (.clk(clk), .reset_pin_n(reset_pin_n), .limp_home_input(limp_home_input),
        .cmd_word(cmd_word), .cmd_load(cmd_load));
    lowside_channel_fault_diag #(.OVL_CYC(OVL), .OL_CYC(OL), .HOLD_CYC(HLD)) DUT (
        .clk(clk), .nrst(nrst), .reset_pin_n(reset_pin_n), .limp_home_input(limp_home_input),
        .cmd_word(cmd_word), .cmd_load(cmd_load), .overload(overload), .over_temp(over_temp),
        .open_load(open_load), .gate_on(gate_on), .diag_current_en(diag_current_en),
        .diag_word(diag_word), .cmd_state(cmd_state), .held(held));
    // ==================================================
    // Helpers: random source, expectations, compare, verdict
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Gates on for code 01; current source and open-load flag only when off or idle
    function automatic logic [31:0] expect_of(input logic [15:0] c, input logic [7:0] ol);
        logic [31:0] e;
        e = 32'h00000000;
        for (int n = 0; n < 8; n++) begin
            e[24+n] = c[2*n+1];
            e[16+n] = c[2*n+:2] == 2'h1;
            e[2*n] = ol[n] && c[2*n+1];
        end
        return e;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic conclude;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==================================================
    // Main sequence
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        check({gate_on, cmd_state}, {8'h00, 16'hFFFF});
        check(diag_word, 16'hFFFF);
        host.send(16'h0000);
        // Flags clear one edge after standby, the word one edge later
        repeat (2) @(negedge clk);
        check({diag_current_en, diag_word}, 24'h000000);
        host.send(16'h5555);
        @(negedge clk);
        // Short overload bursts never trip
        repeat (5) begin
            overload[0] = 1'b1;
            repeat (OVL - 1) @(negedge clk);
            overload[0] = 1'b0;
            @(negedge clk);
        end
        repeat (3) @(negedge clk);
        check({gate_on, diag_word[1]}, 9'h1FE);
        overload[0] = 1'b1;
        for (k = 0; k < 40 && gate_on[0] === 1'b1; k++) @(negedge clk);
        check(k >= OVL && k <= OVL + 4, 1'b1);
        if (k == 40) conclude();
        overload[0] = 1'b0;
        host.send(16'h5555);
        repeat (3) @(negedge clk);
        check({gate_on[0], diag_word[1:0]}, 3'b010);
        over_temp = 8'h09;
        repeat (5) @(negedge clk);
        check({gate_on[3], diag_word[7:6]}, 3'b010);
        over_temp = 8'h00;
        repeat (3) @(negedge clk);
        host.send(16'h0000);
        repeat (2) @(negedge clk);
        check(diag_word, 16'h0000);
        // Open load under every code, then random commands and loads
        for (i = 0; i < 6; i++) begin
            rng = xs(rng);
            w = (i == 0) ? 16'h4E4E : rng[15:0];
            host.send(w);
            open_load = (i == 0) ? 8'hFF : rng[23:16];
            repeat (OL + 6) @(negedge clk);
            check({diag_current_en, gate_on, diag_word}, expect_of(w, open_load));
            open_load = 8'h00;
            host.send(16'h0000);
        end
        // Reset pin, then limp-home: idle, commands refused
        for (i = 0; i < 2; i++) begin
            host.send(16'h5555);
            host.pins(i[0], 1'b1);
            repeat (HLD + 6) @(negedge clk);
            host.send(16'h0000);
            check({held, gate_on, cmd_state}, {1'b1, 8'h00, 16'hFFFF});
            host.pins(i[0], 1'b0);
            repeat (5) @(negedge clk);
            check(held, 1'b0);
        end
        conclude();
    end
endmodule
`default_nettype wire
